/* slrx_mode_config.sv */
// link receiver mode configuration: register bank, link copy steering, check flags
// assumes a synchronous register port with one-cycle write and read strobes
`timescale 1ns/10ps
module slrx_mode_config
  import slrx_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [1:0][7:0] MF_CLK_DELAY,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic TWO_LINK_SELECT,
  output logic SECOND_LINK_SYNC_PD,
  output logic [1:0] DESCRAMBLE_EN,
  output logic [7:0] LANE_DESKEW,
  output logic [7:0] LANE_CAPTURE_EN,
  output logic [7:0] CFG_FLAGS
);

  // =====================================================
  // state
  slrx_link_s link_q [NLINK];
  slrx_link_s link_d [NLINK];
  logic [7:0] syncpd_q, syncpd_d;
  logic [7:0] arrange_q, arrange_d;
  logic [7:0] deskew_q, deskew_d;
  logic [7:0] enable_q, enable_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [7:0] flags_q, flags_d;
  logic dual;
  logic sel1;
  logic [NLINK-1:0] combo_bad, k_bad, sub_bad, delay_bad, other_bad;
  logic link_differ;

  // arrangement bits
  assign dual = arrange_q[B_DUAL];
  assign sel1 = arrange_q[B_SEL1];

  // =====================================================
  // register writes and reads
  always_comb
  begin
    slrx_link_s cur;
    int unsigned w;
    cur = '0;
    w = 0;
    link_d = link_q;
    syncpd_d = syncpd_q;
    arrange_d = arrange_q;
    deskew_d = deskew_q;
    enable_d = enable_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    // link parameter writes land in the copy picked by the select bit
    w = sel1 ? 1 : 0;
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        A_SYNCPD: syncpd_d = REG_WDATA;
        A_ARRANGE: arrange_d = REG_WDATA;
        A_LANES: link_d[w].lanes = REG_WDATA;
        A_OPF: link_d[w].opf = REG_WDATA;
        A_KF: link_d[w].kf = REG_WDATA;
        A_CONV: link_d[w].conv = REG_WDATA;
        A_RES: link_d[w].res = REG_WDATA;
        A_SUBW: link_d[w].subw = REG_WDATA;
        A_VERS: link_d[w].vers = REG_WDATA;
        A_DENS: link_d[w].dens = REG_WDATA;
        A_FVAL: link_d[w].fval = REG_WDATA;
        A_DESKEW: deskew_d = REG_WDATA;
        A_ENABLE: enable_d = REG_WDATA;
        default:
        begin
          // status and unmapped addresses ignore writes
        end
      endcase
    end
    // reads show the selected copy; unmapped addresses read zero
    cur = link_q[w];
    if (REG_RD)
    begin
      rvalid_d = 1'b1;
      unique case (REG_ADDR)
        A_FLAGS: rdata_d = flags_q;
        A_SYNCPD: rdata_d = syncpd_q;
        A_ARRANGE: rdata_d = arrange_q;
        A_LANES: rdata_d = cur.lanes;
        A_OPF: rdata_d = cur.opf;
        A_KF: rdata_d = cur.kf;
        A_CONV: rdata_d = cur.conv;
        A_RES: rdata_d = cur.res;
        A_SUBW: rdata_d = cur.subw;
        A_VERS: rdata_d = cur.vers;
        A_DENS: rdata_d = cur.dens;
        A_FVAL: rdata_d = cur.fval;
        A_DESKEW: rdata_d = deskew_q;
        A_ENABLE: rdata_d = enable_q;
        default: rdata_d = R_ZERO;
      endcase
    end
  end

  // =====================================================
  // per-link configuration checks, recomputed every cycle
  genvar gl;
  generate
    for (gl = 0; gl < NLINK; gl++)
    begin : g_chk
      always_comb
      begin
        slrx_link_s p;
        logic hit;
        logic k16ok;
        p = link_q[gl];
        hit = 1'b0;
        k16ok = 1'b0;
        // look the lane, octet, converter and sample mix up in the mode table
        for (int unsigned i = 0; i < NMODE; i++)
        begin
          if (p.lanes[4:0] == MODES[i].l1 && p.opf == MODES[i].f1 &&
              p.conv == MODES[i].m1 && p.vers[4:0] == MODES[i].s1 &&
              (!dual || i >= DUAL_FIRST))
          begin
            hit = 1'b1;
            k16ok = MODES[i].k16;
          end
        end
        combo_bad[gl] = !hit;
        // 32 frames always legal, 16 only where the mode allows it
        k_bad[gl] = !(p.kf[4:0] == K_32 || (p.kf[4:0] == K_16 && k16ok));
        sub_bad[gl] = p.subw[7:5] > SUB_MAX;
        // delay must fall inside the multiframe
        delay_bad[gl] = MF_CLK_DELAY[gl] > {3'h0, p.kf[4:0]};
        other_bad[gl] = (p.fval != p.opf + 8'h01) ||
                        (p.dens[B_HD] != (p.opf == R_ZERO)) ||
                        (p.dens[4:0] != 5'h00) ||
                        (p.res[7:6] != 2'h0) || (p.res[4:0] != N_16) ||
                        (p.subw[4:0] != N_16) ||
                        (p.vers[7:5] != VER_B);
      end
    end
  endgenerate

  // second copy must mirror the first when two links run
  assign link_differ = dual && (link_q[0] != link_q[1]);

  // =====================================================
  // status assembly; second link counts only in two-link operation
  always_comb
  begin
    flags_d = R_ZERO;
    flags_d[F_DELAY] = delay_bad[0] | (dual & delay_bad[1]);
    flags_d[F_COMBO] = combo_bad[0] | (dual & combo_bad[1]) | link_differ;
    flags_d[F_KBAD] = k_bad[0] | (dual & k_bad[1]);
    flags_d[F_SUB] = sub_bad[0] | (dual & sub_bad[1]);
    flags_d[F_OTHER] = other_bad[0] | (dual & other_bad[1]);
  end

  // =====================================================
  // registers; clock enable freezes everything
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int unsigned i = 0; i < NLINK; i++)
      begin
        link_q[i] <= '0;
      end
      syncpd_q <= R_ZERO;
      arrange_q <= R_ZERO;
      deskew_q <= R_ZERO;
      enable_q <= R_ZERO;
      rdata_q <= R_ZERO;
      rvalid_q <= 1'b0;
      flags_q <= R_ZERO;
    end
    else if (CLK_EN)
    begin
      link_q <= link_d;
      syncpd_q <= syncpd_d;
      arrange_q <= arrange_d;
      deskew_q <= deskew_d;
      enable_q <= enable_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      flags_q <= flags_d;
    end
  end

  // =====================================================
  // outputs
  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign TWO_LINK_SELECT = dual;
  assign SECOND_LINK_SYNC_PD = syncpd_q[B_SYNCPD];
  assign DESCRAMBLE_EN[0] = link_q[0].lanes[B_SCRAM];
  assign DESCRAMBLE_EN[1] = dual & link_q[1].lanes[B_SCRAM];
  assign LANE_DESKEW = deskew_q;
  assign LANE_CAPTURE_EN = enable_q;
  assign CFG_FLAGS = flags_q;

endmodule : slrx_mode_config

/* slrx_pkg.sv */
// link receiver mode configuration: constants, register map, field layout, mode table
// assumes one register port of the device and a single 100 MHz clock
// Contract
// - single link accepts modes 0 to 7, 9 and 10; two links accept only modes 4 to 7, 9 and 10.
// - bit 3 of link_arrangement_select selects two-link operation; zero selects one link.
// - bit 2 of link_arrangement_select steers link parameter writes to the second copy.
// - bit 0 of sync_out_buffer_power powers down the second sync request output buffer.
// - status link_config_check_flags bit 5 flags an illegal multiframe clock delay.
// - status link_config_check_flags bit 3 flags an unsupported lane, converter, octet, sample mix.
// - status link_config_check_flags bit 2 flags an illegal frames per multiframe.
// - status link_config_check_flags bit 1 flags an illegal subclass.
// - deskew mask lane_deskew_mask then enable mask lane_enable_mask; only enabled lanes capture.
// - lane_count_and_scramble bit 7 enables descrambling; bits 4:0 hold lanes minus one.
// - octets_per_frame_minus_one holds octets minus one, octets_per_frame_value the octet count; both agree.
// - frames_per_multiframe_minus_one holds frames minus one: 0x1F in modes 0, 4 and 9, 0x0F or 0x1F otherwise.
// - converter_count_minus_one holds converters per link minus one.
// - subclass_and_sample_width bits 7:5 pick subclass 0 or 1; bits 4:0 hold 0xF.
// - version_and_samples_per_frame bits 7:5 at 0x1 pick revision B; bits 4:0 samples minus one.
// - mode 0: eight lanes, one octet, four converters, one sample, high density.
// - mode 1: eight lanes, two octets, four converters, two samples, no density.
// - mode 2: four lanes, two octets, four converters, one sample, mask 0x0F.
// - mode 3: two lanes, four octets, four converters, octet field 0x03.
package slrx_pkg;
  // =====================================================
  // register offsets
  localparam logic [11:0] A_FLAGS = 12'h030;
  localparam logic [11:0] A_SYNCPD = 12'h203;
  localparam logic [11:0] A_ARRANGE = 12'h300;
  localparam logic [11:0] A_LANES = 12'h453;
  localparam logic [11:0] A_OPF = 12'h454;
  localparam logic [11:0] A_KF = 12'h455;
  localparam logic [11:0] A_CONV = 12'h456;
  localparam logic [11:0] A_RES = 12'h457;
  localparam logic [11:0] A_SUBW = 12'h458;
  localparam logic [11:0] A_VERS = 12'h459;
  localparam logic [11:0] A_DENS = 12'h45a;
  localparam logic [11:0] A_DESKEW = 12'h46c;
  localparam logic [11:0] A_FVAL = 12'h476;
  localparam logic [11:0] A_ENABLE = 12'h47d;
  // =====================================================
  // field positions
  localparam int unsigned B_DUAL = 3;
  localparam int unsigned B_SEL1 = 2;
  localparam int unsigned B_SYNCPD = 0;
  localparam int unsigned B_SCRAM = 7;
  localparam int unsigned B_HD = 7;
  localparam int unsigned F_DELAY = 5;
  localparam int unsigned F_COMBO = 3;
  localparam int unsigned F_KBAD = 2;
  localparam int unsigned F_SUB = 1;
  localparam int unsigned F_OTHER = 0;
  // =====================================================
  // reset and legal values
  localparam logic [7:0] R_ZERO = 8'h00;
  localparam logic [4:0] K_32 = 5'h1f;
  localparam logic [4:0] K_16 = 5'h0f;
  localparam logic [4:0] N_16 = 5'h0f;
  localparam logic [2:0] SUB_MAX = 3'h1;
  localparam logic [2:0] VER_B = 3'h1;
  localparam int unsigned NLINK = 2;
  localparam int unsigned NMODE = 10;
  localparam int unsigned DUAL_FIRST = 4;
  // =====================================================
  // one link's parameter copy
  typedef struct packed {
    logic [7:0] lanes;
    logic [7:0] opf;
    logic [7:0] kf;
    logic [7:0] conv;
    logic [7:0] res;
    logic [7:0] subw;
    logic [7:0] vers;
    logic [7:0] dens;
    logic [7:0] fval;
  } slrx_link_s;
  // supported mode: lanes-1, octets-1, converters-1, samples-1, 16 frames allowed
  typedef struct packed {
    logic [4:0] l1;
    logic [7:0] f1;
    logic [7:0] m1;
    logic [4:0] s1;
    logic k16;
  } slrx_mode_s;
  // table rows are modes 0,1,2,3,4,5,6,7,9,10; rows from DUAL_FIRST allow two links
  localparam slrx_mode_s MODES [NMODE] = '{
    '{5'h07, 8'h00, 8'h03, 5'h00, 1'b0},
    '{5'h07, 8'h01, 8'h03, 5'h01, 1'b1},
    '{5'h03, 8'h01, 8'h03, 5'h00, 1'b1},
    '{5'h01, 8'h03, 8'h03, 5'h00, 1'b1},
    '{5'h03, 8'h00, 8'h01, 5'h00, 1'b0},
    '{5'h03, 8'h01, 8'h01, 5'h01, 1'b1},
    '{5'h01, 8'h01, 8'h01, 5'h00, 1'b1},
    '{5'h00, 8'h03, 8'h01, 5'h00, 1'b1},
    '{5'h01, 8'h00, 8'h00, 5'h00, 1'b0},
    '{5'h00, 8'h01, 8'h00, 5'h00, 1'b1}
  };
endpackage : slrx_pkg

/* slrx_mode_config_properties.sv */
// checker: port-level properties of the mode configuration bank
// assumes a bind onto slrx_mode_config and one clock domain
`timescale 1ns/10ps
module slrx_mode_config_properties
  import slrx_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [1:0][7:0] MF_CLK_DELAY,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic TWO_LINK_SELECT,
  input wire logic SECOND_LINK_SYNC_PD,
  input wire logic [1:0] DESCRAMBLE_EN,
  input wire logic [7:0] LANE_DESKEW,
  input wire logic [7:0] LANE_CAPTURE_EN,
  input wire logic [7:0] CFG_FLAGS
);
  // ==================================================
  // taken register requests
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_wr(a);
    CLK_EN && REG_WR && REG_ADDR == a;
  endsequence
  sequence s_rd(a);
    CLK_EN && REG_RD && !REG_WR && REG_ADDR == a;
  endsequence
  // ==================================================
  // properties
  AST_RVALID_ON:
    assert property (CLK_EN && REG_RD |=> REG_RVALID) else $error("read answer missing");
  AST_RVALID_OFF:
    assert property (CLK_EN && !REG_RD |=> !REG_RVALID) else $error("read answer without read");
  AST_RDATA_HOLD:
    assert property (CLK_EN && !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  AST_DUAL:
    assert property (s_wr(A_ARRANGE) |=> TWO_LINK_SELECT == $past(REG_WDATA[B_DUAL])) else $error("link select");
  AST_SYNCPD:
    assert property (s_wr(A_SYNCPD) |=> SECOND_LINK_SYNC_PD == $past(REG_WDATA[B_SYNCPD])) else $error("sync pd");
  AST_DESKEW:
    assert property (s_wr(A_DESKEW) |=> LANE_DESKEW == $past(REG_WDATA)) else $error("deskew mask");
  AST_ENABLE:
    assert property (s_wr(A_ENABLE) |=> LANE_CAPTURE_EN == $past(REG_WDATA)) else $error("enable mask");
  AST_RDBACK:
    assert property (s_wr(A_DESKEW) ##1 s_rd(A_DESKEW) |=> REG_RDATA == LANE_DESKEW) else $error("readback");
  AST_RSVD:
    assert property (CFG_FLAGS[7:6] == 2'b00 && !CFG_FLAGS[4]) else $error("reserved flag bits set");
  AST_FREEZE:
    assert property (!CLK_EN |=> $stable(CFG_FLAGS) && $stable(LANE_CAPTURE_EN)) else $error("state moved");
endmodule : slrx_mode_config_properties

bind slrx_mode_config slrx_mode_config_properties u_props (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .MF_CLK_DELAY(MF_CLK_DELAY),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .TWO_LINK_SELECT(TWO_LINK_SELECT),
  .SECOND_LINK_SYNC_PD(SECOND_LINK_SYNC_PD), .DESCRAMBLE_EN(DESCRAMBLE_EN), .LANE_DESKEW(LANE_DESKEW),
  .LANE_CAPTURE_EN(LANE_CAPTURE_EN), .CFG_FLAGS(CFG_FLAGS));

/* slrx_tx_model.sv */
// partner: transmitter side handing its multiframe clock delay to both links
// assumes the receiver bank's clock and reset
`timescale 1ns/10ps
module slrx_tx_model
  import slrx_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] REQ_DELAY,
  output logic [1:0][7:0] MF_CLK_DELAY
);
  logic [7:0] dly_q;
  logic [7:0] dly_d;
  // ==================================================
  // next delay figure
  always_comb dly_d = REQ_DELAY;
  // registered delay
  always_ff @(posedge REF_CLK or negedge ARST_N)
    if (!ARST_N) dly_q <= 8'h00;
    else dly_q <= dly_d;
  // second link gets the same figure as the first
  assign MF_CLK_DELAY = {dly_q, dly_q};
endmodule : slrx_tx_model

/* slrx_mode_config_test.sv */
// testbench: register traffic, mode table programming, check flags
// assumes the bank, its checker and the transmitter model
`timescale 1ns/10ps
module slrx_mode_config_test
  import slrx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] tx_dly = 8'h00;
  logic [1:0][7:0] mf_dly;
  logic [7:0] rdata, deskew, cap_en, flags;
  logic rvalid, two_link, sync_pd;
  logic [1:0] dscr;
  logic [7:0] expq[$];
  int err_count = 0;
  int checked = 0;
  slrx_mode_config dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .CLK_EN(clk_en), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .MF_CLK_DELAY(mf_dly), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .TWO_LINK_SELECT(two_link), .SECOND_LINK_SYNC_PD(sync_pd), .DESCRAMBLE_EN(dscr),
    .LANE_DESKEW(deskew), .LANE_CAPTURE_EN(cap_en), .CFG_FLAGS(flags));
  slrx_tx_model u_tx (.REF_CLK(ref_clk), .ARST_N(arst_n), .REQ_DELAY(tx_dly), .MF_CLK_DELAY(mf_dly));
  // ==================================================
  // clock
  always #5 ref_clk = ~ref_clk;
  // ==================================================
  // tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
    wr(a, d);
    reg_rd <= 1'b1;
    expq.push_back(d);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : wr_rd
  task automatic prog(input int r);
    slrx_mode_s m;
    m = MODES[r];
    wr(A_LANES, {3'h0, m.l1});
    wr(A_OPF, m.f1);
    wr(A_KF, {3'h0, K_32});
    wr(A_CONV, m.m1);
    wr(A_RES, 8'h0f);
    wr(A_SUBW, 8'h2f);
    wr(A_VERS, {VER_B, m.s1});
    wr(A_DENS, (m.f1 == 8'h00) ? 8'h80 : 8'h00);
    wr(A_FVAL, m.f1 + 8'h01);
  endtask : prog
  task automatic tally_and_finish;
    if (expq.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // read answers against the oldest note
  always @(posedge ref_clk)
    if (rvalid === 1'b1)
    begin
      if (expq.size() == 0) chk("unrequested read", 8'h00, 8'hff);
      else chk("read data", expq.pop_front(), rdata);
    end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    logic [7:0] mk;
    void'($urandom(37));
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(A_DESKEW, 8'h00);
    rd(A_FLAGS, 8'h0d);
    for (int r = 0; r < 4; r++)
    begin
      mk = 8'((9'h001 << (MODES[r].l1 + 5'h01)) - 9'h001);
      prog(r);
      wr_rd(A_DESKEW, mk);
      wr_rd(A_ENABLE, mk);
      chk("capture lanes", mk, cap_en);
      chk("deskew lanes", mk, deskew);
      rd(A_FLAGS, 8'h00);
      chk("flag pins", 8'h00, flags);
    end
    wr(A_KF, 8'h0e);
    rd(A_FLAGS, 8'h04);
    wr(A_KF, 8'h0f);
    rd(A_FLAGS, 8'h00);
    wr(A_SUBW, 8'h4f);
    rd(A_FLAGS, 8'h02);
    wr(A_SUBW, 8'h0f);
    rd(A_FLAGS, 8'h00);
    tx_dly <= 8'($urandom_range(15, 0));
    repeat (3) @(posedge ref_clk);
    rd(A_FLAGS, 8'h00);
    tx_dly <= 8'($urandom_range(255, 16));
    repeat (3) @(posedge ref_clk);
    rd(A_FLAGS, 8'h20);
    tx_dly <= 8'h00;
    wr(A_LANES, 8'h05);
    // frames field still holds 16, which no longer has a matching mode to allow it
    rd(A_FLAGS, 8'h0c);
    wr(A_LANES, 8'h81);
    @(negedge ref_clk);
    chk("descramble", 8'h01, {6'h00, dscr});
    wr(A_ARRANGE, 8'h04);
    prog(3);
    wr(A_LANES, 8'h81);
    wr(A_ARRANGE, 8'h0c);
    @(negedge ref_clk);
    chk("two link", 8'h01, {7'h00, two_link});
    chk("descramble", 8'h03, {6'h00, dscr});
    // first copy keeps 16 frames, illegal once its mode is refused for two links
    rd(A_FLAGS, 8'h0c);
    wr(A_CONV, 8'h02);
    rd(A_CONV, 8'h02);
    wr(A_ARRANGE, 8'h08);
    rd(A_CONV, 8'h03);
    prog(4);
    wr(A_ARRANGE, 8'h0c);
    prog(4);
    rd(A_FLAGS, 8'h00);
    wr(A_SYNCPD, 8'h01);
    @(negedge ref_clk);
    chk("sync pd", 8'h01, {7'h00, sync_pd});
    wr(A_FLAGS, 8'hff);
    rd(A_FLAGS, 8'h00);
    rd(12'h7ff, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(A_DESKEW, 8'haa);
    clk_en <= 1'b1;
    rd(A_DESKEW, 8'h03);
    repeat (3) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : slrx_mode_config_test
